// ===== tb/fp_round_fma_datapath_tb.sv
// self-checking bench: operations run through the register map, results compared
// assumes fprd_host as bus master and fprd_core as the device
`timescale 1ns/1ps
module fp_round_fma_datapath_tb;
  import fprd_pkg::*;
  localparam logic [63:0] Z = 64'h0000_0000_0000_0000;
  localparam logic [63:0] D15 = 64'h3ff8_0000_0000_0000;
  localparam logic [63:0] H53 = 64'h3ca0_0000_0000_0000;
  localparam logic [63:0] P1 = 64'h3ff0_0000_0000_0001;
  localparam logic [63:0] P2 = 64'h3ff0_0000_0000_0002;
  localparam logic [63:0] MX = 64'h7fef_ffff_ffff_ffff;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  int n_errors = 0;
  int total_checks = 0;
  // 200 MHz clock
  always #2.5 core_clk_i = ~core_clk_i;
  fprd_core dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  fprd_host host (.core_clk_i(core_clk_i), .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i),
    .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    host.xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  // low word at the lower address
  task automatic wr64(input logic [7:0] a, input logic [63:0] v);
    wr(a, v[31:0]);
    wr(a + 8'h04, v[63:32]);
  endtask
  // one operation: load operands, start, poll done, compare result and masked status
  task automatic t(input logic [2:0] op, input logic [1:0] rm, input logic sgl, input logic [63:0] a,
                   input logic [63:0] b, input logic [63:0] c, input logic [63:0] res, input logic [4:0] st,
                   input logic [4:0] mk);
    logic [31:0] lo, hi, s;
    int n;
    wr64(REG_OPND, a);
    wr64(REG_OPND + 8'h08, b);
    wr64(REG_OPND + 8'h10, c);
    wr(REG_CTRL, {25'h0, sgl, rm, op, 1'b1});
    n = 0;
    do begin
      rd(REG_STAT, s);
      n++;
    end while (s[STAT_DONE] !== 1'b1 && n < 40);
    // a poll that runs out of tries counts as a mismatch
    if (s[STAT_DONE] !== 1'b1) begin
      n_errors++;
      $display("unexpected done: expected 1 seen %b", s[STAT_DONE]);
    end
    rd(REG_RES_LO, lo);
    rd(REG_RES_HI, hi);
    chk("result", res, {hi, lo});
    chk("status", {59'h0, st | 5'h02}, {59'h0, s[4:0] & (mk | 5'h03)});
  endtask
  task automatic print_verdict;
    n_errors += host.n_timeouts;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    logic [31:0] q;
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    // unmapped place reads zero, writes ignored
    wr(8'h40, 32'h1234_5678);
    rd(8'h40, q);
    chk("unmapped", Z, {32'h0, q});
    // operand write while busy is dropped; status shows busy, not done
    wr64(REG_OPND, D15);
    wr64(REG_OPND + 8'h08, D15);
    wr(REG_CTRL, {25'h0, 1'b0, 2'h0, 3'h2, 1'b1});
    wr(REG_OPND, 32'hdead_beef);
    rd(REG_STAT, q);
    chk("busy", 64'h0000_0000_0000_0001, {62'h0, q[1:0]});
    rd(REG_OPND, q);
    chk("refused write", Z, {32'h0, q});
    t(3'h2, 2'h0, 1'b0, D15, D15, Z, 64'h4002_0000_0000_0000, 5'h00, 5'h1c);
    // midway tie in every mode, low bit even
    for (int m = 0; m < 4; m++) begin
      t(3'h0, 2'(m), 1'b0, ONE_DBL, Z, H53, (m == 2) ? P1 : ONE_DBL, 5'h04, 5'h1c);
    end
    t(3'h0, 2'h0, 1'b0, P1, Z, H53, P2, 5'h04, 5'h1c);
    t(3'h0, 2'h3, 1'b0, 64'hbff0_0000_0000_0000, Z, 64'hbca0_0000_0000_0000, 64'hbff0_0000_0000_0001, 5'h04,
      5'h1c);
    t(3'h0, 2'h2, 1'b0, 64'hbff0_0000_0000_0000, Z, 64'hbca0_0000_0000_0000, 64'hbff0_0000_0000_0000, 5'h04,
      5'h1c);
    t(3'h0, 2'h2, 1'b0, 64'h3fff_ffff_ffff_ffff, Z, H53, 64'h4000_0000_0000_0000, 5'h04, 5'h1c);
    t(3'h0, 2'h0, 1'b0, MX, Z, 64'h7c90_0000_0000_0000, 64'h7ff0_0000_0000_0000, 5'h0c, 5'h1c);
    t(3'h0, 2'h1, 1'b0, MX, Z, 64'h7c90_0000_0000_0000, MX, 5'h04, 5'h14);
    t(3'h1, 2'h0, 1'b0, 64'h4000_0000_0000_0000, Z, 64'h3fe0_0000_0000_0000, D15, 5'h00, 5'h1c);
    // fused: the product alone is inexact, the whole result is exact
    t(3'h3, 2'h0, 1'b0, P1, P1, 64'hbff0_0000_0000_0002, 64'h3970_0000_0000_0000, 5'h00,
      5'h1c);
    t(3'h4, 2'h0, 1'b0, P1, P1, P2, 64'h3970_0000_0000_0000, 5'h00, 5'h1c);
    t(3'h5, 2'h0, 1'b0, D15, D15, Z, 64'hc002_0000_0000_0000, 5'h00, 5'h1c);
    t(3'h6, 2'h0, 1'b0, P1, P1, P2, 64'hb970_0000_0000_0000, 5'h00, 5'h1c);
    // denormal operand and denormal result
    t(3'h2, 2'h0, 1'b0, 64'h0000_0000_0000_0001, 64'h7e70_0000_0000_0000, Z, 64'h3b50_0000_0000_0000, 5'h00,
      5'h1c);
    t(3'h2, 2'h0, 1'b0, 64'h0010_0000_0000_0000, 64'h3fe0_0000_0000_0000, Z, 64'h0008_0000_0000_0000, 5'h00,
      5'h1c);
    // single precision rounding at bits 23 and 24
    t(3'h0, 2'h0, 1'b1, ONE_DBL, Z, 64'h3e70_0000_0000_0000, ONE_DBL, 5'h04, 5'h1c);
    t(3'h0, 2'h0, 1'b1, ONE_DBL, Z, 64'h3e88_0000_0000_0000, 64'h3ff0_0000_4000_0000, 5'h04,
      5'h1c);
    t(3'h0, 2'h0, 1'b1, P1, Z, Z, ONE_DBL, 5'h14, 5'h1c);
    // control readback keeps op, mode and width, start reads zero
    rd(REG_CTRL, q);
    chk("control", 64'h0000_0000_0000_0040, {32'h0, q});
    print_verdict();
  end
endmodule

// ===== tb/fprd_host.sv
// wishbone master standing in for the register file and issue logic
// assumes a classic single-cycle wishbone slave clocked by core_clk_i
`timescale 1ns/1ps
module fprd_host (
  // clock and slave answer
  input wire logic core_clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  // request lines
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  int n_timeouts = 0;
  // idle bus from time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end
  // one request held until ack is seen; entry edge leaves cyc low one cycle
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge core_clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= a;
    wb_sel_o <= 4'hf;
    wb_dat_o <= d;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_i !== 1'b1 && n < 32);
    if (wb_ack_i !== 1'b1) begin
      n_timeouts++;
      $display("unexpected ack: expected 1 seen %b", wb_ack_i);
    end
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
  endtask
endmodule

// ===== verilog/fprd_core.sv
// fused multiply-add / add / multiply datapath with one final rounding, wishbone slave
// assumes classic wishbone in the core_clk_i domain; infinities and nans are not special-cased
`timescale 1ns/1ps
// Overview of operation
// (RULE_01) exponent carried with two extra bits
// (RULE_02) denormal operands prenormalized using extra bit
// (RULE_03) accumulator: sign, carry, lead, fraction, g/r/x
// (RULE_04) sticky ORs every bit below round
// (RULE_05) left shifts bring zeros into round
// (RULE_06) grx decides exact, lower, midway, higher
// (RULE_07) rounding carry shifts right, bumps exponent
// (RULE_08) bits below rounding point stored zero
// (RULE_09) single guard/round/sticky at bits 24-52
// (RULE_10) any nonzero grx flags inexact
// (RULE_11) nearest: guard decides, ties to even
// (RULE_12) nearest at max magnitude: guard picks infinity
// (RULE_13) zero/plus/minus modes pick bracketing candidate
// (RULE_14) narrow results normalized or denormalized first
// (RULE_15) single ops need single operands; doubles widen
// (RULE_16) product and sum exact, one rounding
// (RULE_17) product carry shifts right into lead
// (RULE_18) all product bits add; shifted-out bits sticky
// (RULE_19) normalization leaves addend sticky in place
// (RULE_20) fused guard 53, round 54, sticky 55+
// (RULE_21) negative variants negate rounded result
// (RULE_22) status only for the whole operation
// (RULE_23) rounding mode 00 near,01 zero,10 plus,11 minus
module fprd_core
  import fprd_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  fprd_state_t state_q;
  logic [31:0] opw_q [OPND_WORDS];
  fprd_op_t op_q;
  fprd_rmode_t mode_q;
  logic sgl_q, busy_q, done_q, inexact_q, ovf_q, perr_q;
  logic [63:0] res_q;
  logic ack_q;
  logic [31:0] rdat_q;
  // pipeline registers
  logic [PROD_W-1:0] prod_q;
  logic signed [EXP_W-1:0] pexp_q, cexp_q, aexp_q, sexp_q, nexp_q;
  logic psign_q, csign_q, asign_q, bsign_q, ssign_q, nsign_q;
  logic [SIG_W-1:0] csig_q;
  logic [PROD_W:0] xa_q, xb_q;
  logic [PROD_W+1:0] sum_q;
  logic [PROD_W-1:0] nm_q;
  logic xs_q;

  fprd_rnd_if rif ();

  logic req, wr_en, start;
  logic [63:0] opa, opb, opc;
  logic sa, sb, sc;
  logic signed [EXP_W-1:0] ea, eb, ec;
  logic [SIG_W-1:0] ma, mb, mc;

  // merge one bus word under its byte enables
  function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction

  // write lands on the edge where the master sees ack
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_en = req & wb_we_i & ack_q;
  assign start = wr_en && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_START] && !busy_q;

  // one-cycle ack, dropped the cycle after it was given
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // read data captured as ack rises; unmapped reads return zero
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      case (wb_adr_i)
        REG_CTRL: rdat_q <= {25'h0, sgl_q, mode_q, op_q, 1'b0};
        REG_STAT: rdat_q <= {27'h0, perr_q, ovf_q, inexact_q, done_q, busy_q};
        REG_RES_LO: rdat_q <= res_q[31:0];
        REG_RES_HI: rdat_q <= res_q[63:32];
        default: begin
          if (wb_adr_i >= REG_OPND && wb_adr_i < REG_RES_LO && wb_adr_i[1:0] == 2'b00) begin
            rdat_q <= opw_q[3'(wb_adr_i[7:2] - REG_OPND[7:2])];
          end else begin
            rdat_q <= 32'h0000_0000;
          end
        end
      endcase
    end
  end
  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

  // operand words; writes while busy are ignored so a running op stays exact
  for (genvar i = 0; i < OPND_WORDS; i++) begin : g_opw
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        opw_q[i] <= 32'h0000_0000;
      end else if (wr_en && !busy_q && wb_adr_i == 8'(REG_OPND + 4 * i)) begin
        opw_q[i] <= byte_merge(opw_q[i], wb_dat_i, wb_sel_i);
      end
    end
  end

  // control latched on start
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_q <= OP_ADD;
      mode_q <= RM_NEAR;
      sgl_q <= 1'b0;
    end else if (start) begin
      op_q <= fprd_op_t'(wb_dat_i[CTRL_OP_LSB +: 3]);
      mode_q <= fprd_rmode_t'(wb_dat_i[CTRL_RM_LSB +: 2]); // RULE_23
      sgl_q <= wb_dat_i[CTRL_SGL];
    end
  end

  // operand selection: add uses b = 1.0, multiply uses c = 0
  assign opa = {opw_q[1], opw_q[0]};
  assign opb = (op_q == OP_ADD || op_q == OP_SUB) ? ONE_DBL : {opw_q[3], opw_q[2]};
  assign opc = (op_q == OP_MUL) ? 64'h0000_0000_0000_0000 : {opw_q[5], opw_q[4]};

  fprd_unpack u_unp_a (.opnd_i(opa), .sign_o(sa), .exp_o(ea), .sig_o(ma));
  fprd_unpack u_unp_b (.opnd_i(opb), .sign_o(sb), .exp_o(eb), .sig_o(mb));
  fprd_unpack u_unp_c (.opnd_i(opc), .sign_o(sc), .exp_o(ec), .sig_o(mc));

  // sequencer: one stage per cycle, idle until the next start
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: state_q <= start ? ST_MUL : ST_IDLE;
        ST_MUL: state_q <= ST_ALIGN;
        ST_ALIGN: state_q <= ST_ADD;
        ST_ADD: state_q <= ST_NORM;
        ST_NORM: state_q <= ST_RND;
        ST_RND: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // multiply: exact 106-bit product of prenormalized significands
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prod_q <= '0;
      pexp_q <= '0;
      psign_q <= 1'b0;
      csig_q <= '0;
      cexp_q <= '0;
      csign_q <= 1'b0;
    end else if (state_q == ST_MUL) begin
      prod_q <= ma * mb; // RULE_16
      pexp_q <= (ma == '0 || mb == '0) ? EXP_ZERO : EXP_W'(ea + eb - EXP_BIAS);
      psign_q <= sa ^ sb;
      csig_q <= mc;
      cexp_q <= ec;
      csign_q <= sc ^ (op_q == OP_SUB || op_q == OP_MSUB || op_q == OP_NMSUB);
    end
  end

  // align: smaller exponent shifted right, lost bits folded into X'
  logic [PROD_W-1:0] pn, big, sml;
  logic signed [EXP_W-1:0] pe, dexp;
  logic [PROD_W:0] ext, shd;
  logic lost, swap;
  always_comb begin
    pn = prod_q[PROD_W-1] ? prod_q : prod_q << 1; // RULE_17
    pe = (prod_q == '0) ? EXP_ZERO : pexp_q + EXP_W'(prod_q[PROD_W-1]);
    swap = pe < cexp_q;
    big = swap ? {csig_q, 53'h0} : pn;
    sml = swap ? pn : {csig_q, 53'h0};
    dexp = swap ? cexp_q - pe : pe - cexp_q;
    ext = {sml, 1'b0};
    if (dexp > EXP_W'(SHIFT_MAX)) begin
      shd = '0;
      lost = |sml;
    end else begin
      shd = ext >> dexp[6:0]; // RULE_18
      lost = (shd << dexp[6:0]) != ext;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xa_q <= '0;
      xb_q <= '0;
      aexp_q <= '0;
      asign_q <= 1'b0;
      bsign_q <= 1'b0;
    end else if (state_q == ST_ALIGN) begin
      xa_q <= {big, 1'b0};
      xb_q <= {shd[PROD_W:1], shd[0] | lost}; // RULE_04
      aexp_q <= swap ? cexp_q : pe;
      asign_q <= swap ? csign_q : psign_q;
      bsign_q <= swap ? psign_q : csign_q;
    end
  end

  // add or subtract magnitudes; X' takes part as the lowest bit
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sum_q <= '0;
      ssign_q <= 1'b0;
      sexp_q <= '0;
    end else if (state_q == ST_ADD) begin
      sexp_q <= aexp_q;
      if (asign_q == bsign_q) begin
        sum_q <= {1'b0, xa_q} + {1'b0, xb_q};
        ssign_q <= asign_q;
      end else if (xa_q > xb_q) begin
        sum_q <= {1'b0, xa_q - xb_q};
        ssign_q <= asign_q;
      end else if (xa_q < xb_q) begin
        sum_q <= {1'b0, xb_q - xa_q};
        ssign_q <= bsign_q;
      end else begin
        sum_q <= '0;
        ssign_q <= (mode_q == RM_MINF);
      end
    end
  end

  // normalize then put into denormal form for the target precision
  logic [7:0] lz;
  logic [PROD_W-1:0] n1, n2;
  logic x1, x2;
  logic signed [EXP_W-1:0] e1, emin, ddn;
  always_comb begin
    lz = fprd_lzc({sum_q[PROD_W:1], 22'h0});
    if (sum_q[PROD_W+1]) begin
      n1 = sum_q[PROD_W+1:2]; // RULE_03
      x1 = sum_q[1] | sum_q[0];
      e1 = sexp_q + EXP_W'(1);
    end else if (sum_q[PROD_W:1] == '0) begin
      n1 = '0;
      x1 = sum_q[0];
      e1 = EXP_ZERO;
    end else begin
      n1 = sum_q[PROD_W:1] << lz; // RULE_05
      x1 = sum_q[0]; // RULE_19
      e1 = sexp_q - EXP_W'(lz);
    end
    emin = sgl_q ? SGL_EMIN : DBL_EMIN;
    ddn = emin - e1;
    if (e1 >= emin) begin
      n2 = n1;
      x2 = x1;
    end else if (ddn > EXP_W'(SHIFT_MAX)) begin
      n2 = '0;
      x2 = x1 | (|n1);
    end else begin
      n2 = n1 >> ddn[6:0]; // RULE_14
      x2 = x1 | ((n2 << ddn[6:0]) != n1);
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nm_q <= '0;
      xs_q <= 1'b0;
      nexp_q <= '0;
      nsign_q <= 1'b0;
    end else if (state_q == ST_NORM) begin
      nm_q <= n2;
      xs_q <= x2;
      nexp_q <= (e1 < emin) ? emin : e1;
      nsign_q <= ssign_q;
    end
  end

  assign rif.nm = nm_q;
  assign rif.xs = xs_q;
  assign rif.sign = nsign_q;
  assign rif.exp = nexp_q;
  assign rif.mode = mode_q;
  assign rif.sgl = sgl_q;
  fprd_round u_round (.rif(rif.rnd));

  // result and status written only when the whole operation ends
  logic negate;
  assign negate = (op_q == OP_NMADD || op_q == OP_NMSUB);
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      res_q <= 64'h0000_0000_0000_0000;
      inexact_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (state_q == ST_RND) begin
      res_q <= {rif.res[63] ^ negate, rif.res[62:0]}; // RULE_21
      inexact_q <= rif.inexact; // RULE_22
      ovf_q <= rif.ovf;
    end
  end

  // busy/done; single precision with double-only operand bits flags an error
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      perr_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
      done_q <= 1'b0;
      perr_q <= wb_dat_i[CTRL_SGL] && ((opw_q[0][SGL_LOW_W-1:0] | opw_q[2][SGL_LOW_W-1:0]
                | opw_q[4][SGL_LOW_W-1:0]) != '0); // RULE_15
    end else if (state_q == ST_RND) begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence launch_s;
    state_q == ST_IDLE && start;
  endsequence
  sequence finish_s;
    busy_q ##1 (busy_q && state_q == ST_RND) ##1 (done_q && !busy_q);
  endsequence

  pipe_done_a: assert property (launch_s |-> ##4 finish_s) // RULE_16
    else $error("operation did not finish in five cycles");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  prod_lead_a: assert property (state_q == ST_ALIGN && prod_q != '0 |-> pn[PROD_W-1]) // RULE_17
    else $error("product lead bit not at top after carry shift");
  norm_lead_a: assert property (state_q == ST_RND && nexp_q > (sgl_q ? SGL_EMIN : DBL_EMIN) |-> nm_q[PROD_W-1]) // RULE_19
    else $error("normalized accumulator lacks lead bit");
  rn_guard_a: assert property (state_q == ST_RND && mode_q == RM_NEAR && !rif.guard |-> !rif.inc) // RULE_11
    else $error("nearest rounding incremented with guard clear");
  rz_trunc_a: assert property (state_q == ST_RND && mode_q == RM_ZERO |-> !rif.inc && !rif.ovf
                               || rif.res[62:52] != EXP_INF) // RULE_13
    else $error("toward-zero rounding moved away from zero");
  sgl_low_a: assert property (state_q == ST_RND && sgl_q |=> res_q[SGL_LOW_W-1:0] == '0) // RULE_08
    else $error("single result has nonzero low fraction bits");
  neg_sign_a: assert property (state_q == ST_RND && negate |=> res_q[63] != $past(rif.res[63])) // RULE_21
    else $error("negative variant sign not inverted");
  status_hold_a: assert property (state_q != ST_RND |=> $stable(inexact_q) && $stable(ovf_q)) // RULE_22
    else $error("status changed before the operation ended");
endmodule

// ===== verilog/fprd_pkg.sv
// shared constants, types and helpers of the floating-point round / fused multiply-add datapath
// assumes a single clock domain; operands and results use the 64-bit double register format
package fprd_pkg;
  // exponent arithmetic: 11 stored bits plus two guard positions, signed
  localparam int EXP_W = 13;
  localparam int SIG_W = 53;
  localparam int PROD_W = 106;
  localparam int SGL_LOW_W = 29;
  localparam logic signed [EXP_W-1:0] EXP_BIAS = 13'sh03ff;
  localparam logic signed [EXP_W-1:0] DBL_EMIN = 13'sh0001;
  localparam logic signed [EXP_W-1:0] DBL_EMAX = 13'sh07fe;
  localparam logic signed [EXP_W-1:0] SGL_EMIN = 13'sh0381;
  localparam logic signed [EXP_W-1:0] SGL_EMAX = 13'sh047e;
  localparam logic signed [EXP_W-1:0] EXP_ZERO = 13'sh1800;
  localparam logic [10:0] EXP_INF = 11'h7ff;
  localparam logic [63:0] ONE_DBL = 64'h3ff0_0000_0000_0000;
  localparam logic [6:0] SHIFT_MAX = 7'h6a;
  // wishbone byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_OPND = 8'h08;
  localparam logic [7:0] REG_RES_LO = 8'h20;
  localparam logic [7:0] REG_RES_HI = 8'h24;
  localparam int OPND_WORDS = 6;
  // control and status field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_RM_LSB = 4;
  localparam int CTRL_SGL = 6;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_INEXACT = 2;
  localparam int STAT_OVF = 3;
  localparam int STAT_PERR = 4;
  localparam int PIPE_STAGES = 5;

  typedef enum logic [1:0] {
    RM_NEAR = 2'b00,
    RM_ZERO = 2'b01,
    RM_PINF = 2'b10,
    RM_MINF = 2'b11
  } fprd_rmode_t;

  typedef enum logic [2:0] {
    OP_ADD = 3'b000,
    OP_SUB = 3'b001,
    OP_MUL = 3'b010,
    OP_MADD = 3'b011,
    OP_MSUB = 3'b100,
    OP_NMADD = 3'b101,
    OP_NMSUB = 3'b110
  } fprd_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MUL = 3'b001,
    ST_ALIGN = 3'b010,
    ST_ADD = 3'b011,
    ST_NORM = 3'b100,
    ST_RND = 3'b101
  } fprd_state_t;

  // leading-zero count of a left-justified field, 128 when empty
  function automatic logic [7:0] fprd_lzc(input logic [127:0] v);
    logic [7:0] n;
    logic hit;
    n = 8'h80;
    hit = 1'b0;
    for (int i = 127; i >= 0; i--) begin
      if (!hit && v[i]) begin
        n = 8'(127 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction
endpackage

// ===== verilog/fprd_rnd_if.sv
// bundle between the datapath core and its rounder
// assumes the rounder is purely combinational
`timescale 1ns/1ps
interface fprd_rnd_if;
  import fprd_pkg::*;
  logic [PROD_W-1:0] nm;
  logic xs;
  logic sign;
  logic signed [EXP_W-1:0] exp;
  fprd_rmode_t mode;
  logic sgl;
  logic [63:0] res;
  logic inexact;
  logic ovf;
  logic inc;
  logic guard;
  modport core (output nm, xs, sign, exp, mode, sgl, input res, inexact, ovf, inc, guard);
  modport rnd (input nm, xs, sign, exp, mode, sgl, output res, inexact, ovf, inc, guard);
endinterface

// ===== verilog/fprd_round.sv
// final rounder: picks guard/round/sticky, applies the mode, packs the register image
// assumes a normalized or correct-denormal accumulator from the core
`timescale 1ns/1ps
module fprd_round
  import fprd_pkg::*;
(
  // accumulator in, packed result out
  fprd_rnd_if.rnd rif
);
  logic g, r, x, ix, lsb, carry, lead, all_ones, to_inf;
  logic [SIG_W-1:0] kept;
  logic [SIG_W:0] s54;
  logic [SIG_W-1:0] mant;
  logic [23:0] m2;
  logic [7:0] lz;
  logic signed [EXP_W-1:0] er, e2, emax;

  // rounding position depends on precision
  always_comb begin
    if (rif.sgl) begin
      g = rif.nm[81]; // RULE_09
      r = rif.nm[80];
      x = (|rif.nm[79:0]) | rif.xs;
      kept = {29'h0, rif.nm[105:82]};
      emax = SGL_EMAX;
      all_ones = &kept[23:0];
    end else begin
      g = rif.nm[52]; // RULE_20
      r = rif.nm[51];
      x = (|rif.nm[50:0]) | rif.xs; // RULE_04
      kept = rif.nm[105:53];
      emax = DBL_EMAX;
      all_ones = &kept;
    end
    lsb = kept[0];
    ix = g | r | x; // RULE_06
    // increment choice per mode; tie (100) goes to even
    case (rif.mode)
      RM_NEAR: rif.inc = g & (r | x | lsb); // RULE_11
      RM_ZERO: rif.inc = 1'b0; // RULE_13
      RM_PINF: rif.inc = ~rif.sign & ix;
      RM_MINF: rif.inc = rif.sign & ix;
      default: rif.inc = 1'b0;
    endcase
    s54 = {1'b0, kept} + {{SIG_W{1'b0}}, rif.inc};
    carry = rif.sgl ? s54[24] : s54[SIG_W];
    mant = carry ? s54[SIG_W:1] : s54[SIG_W-1:0]; // RULE_07
    er = rif.exp + EXP_W'(carry);
    lead = rif.sgl ? mant[23] : mant[52];
    rif.ovf = (er > emax) || (rif.mode == RM_NEAR && all_ones && rif.exp == emax && g); // RULE_12
    to_inf = (rif.mode == RM_NEAR) || (rif.mode == RM_PINF && !rif.sign) || (rif.mode == RM_MINF && rif.sign);
    lz = fprd_lzc({mant[23:0], 104'h0});
    m2 = mant[23:0] << lz;
    e2 = er - EXP_W'(lz);
    // pack; bits below the rounding point are written as zero
    if (rif.ovf && to_inf) begin
      rif.res = {rif.sign, EXP_INF, 52'h0};
    end else if (rif.ovf) begin
      rif.res = rif.sgl ? {rif.sign, SGL_EMAX[10:0], 23'h7f_ffff, 29'h0} : {rif.sign, DBL_EMAX[10:0], {52{1'b1}}};
    end else if (rif.sgl && lead) begin
      rif.res = {rif.sign, er[10:0], mant[22:0], {SGL_LOW_W{1'b0}}}; // RULE_08
    end else if (rif.sgl && mant[23:0] != 24'h0) begin
      rif.res = {rif.sign, e2[10:0], m2[22:0], {SGL_LOW_W{1'b0}}};
    end else if (rif.sgl) begin
      rif.res = {rif.sign, 63'h0};
    end else begin
      rif.res = {rif.sign, lead ? er[10:0] : 11'h0, mant[51:0]};
    end
    rif.inexact = ix | rif.ovf; // RULE_10
    rif.guard = g;
  end
endmodule

// ===== verilog/fprd_unpack.sv
// operand unpacker with prenormalization of denormal operands
// assumes a 64-bit double-format operand; purely combinational
`timescale 1ns/1ps
module fprd_unpack
  import fprd_pkg::*;
(
  // operand in
  input wire logic [63:0] opnd_i,
  // unpacked fields out
  output logic sign_o,
  output logic signed [EXP_W-1:0] exp_o,
  output logic [SIG_W-1:0] sig_o
);
  logic [7:0] lz;
  // denormals are shifted up so the lead bit is set; exponent goes below one
  always_comb begin
    sign_o = opnd_i[63];
    lz = fprd_lzc({1'b0, opnd_i[51:0], 75'h0});
    if (opnd_i[62:0] == 63'h0) begin
      exp_o = EXP_ZERO;
      sig_o = '0;
    end else if (opnd_i[62:52] == 11'h0) begin
      sig_o = {1'b0, opnd_i[51:0]} << lz; // RULE_02
      exp_o = DBL_EMIN - EXP_W'(lz); // RULE_01
    end else begin
      sig_o = {1'b1, opnd_i[51:0]};
      exp_o = EXP_W'({2'b00, opnd_i[62:52]});
    end
  end
endmodule
